// >>> mpt_frame_timing.sv
// MAC side frame timing for byte-wide, dual-edge nibble and nibble media links
// How it works
// - Byte mode: enable spans frame, launched on rise
// - Byte mode: bad frame raises transmit error
// - Byte receive sampled on rise, valid frames data
// - Byte receive error reaches client error bit 0
// - Dual-edge: nibbles on both edges, control framed
// - Dual-edge: bad frame drops control at fall
// - Dual-edge receive sampled on both clock edges
// - Dual-edge receive error reaches client bit 0
// - Nibble mode: enable spans frame, launched on rise
// - Nibble mode: bad frame error for one cycle
// - Nibble receive sampled on rise, enable framed
// - Nibble receive error reaches client error bit 0
`timescale 1ns/100ps
`default_nettype none
module mpt_frame_timing (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           srst,
  // Link style select
  input  wire logic [mpt_pkg::MODE_W-1:0]     link_mode,
  // Client transmit stream
  input  wire logic [mpt_pkg::DATA_W-1:0]     client_tx_data,
  input  wire logic                           client_tx_valid,
  output logic                                client_tx_ready,
  input  wire logic                           client_tx_end_of_packet,
  input  wire logic                           client_tx_frame_bad,
  // Client receive stream
  output logic      [mpt_pkg::DATA_W-1:0]     client_rx_data,
  output logic                                client_rx_valid,
  output logic                                client_rx_start_of_packet,
  output logic                                client_rx_end_of_packet,
  output logic      [mpt_pkg::RX_ERR_W-1:0]   client_rx_error,
  // Transmit link
  input  wire logic                           tx_clk,
  output logic      [mpt_pkg::DATA_W-1:0]     byte_tx_bus,
  output logic                                byte_tx_enable,
  output logic                                byte_tx_error,
  // Receive link
  input  wire logic                           rx_clk,
  input  wire logic [mpt_pkg::DATA_W-1:0]     byte_rx_bus,
  input  wire logic                           byte_rx_valid,
  input  wire logic                           byte_rx_error
);
  import mpt_pkg::*;

  typedef struct packed {
    logic              tclk_prev;
    logic              rclk_prev;
    logic [DATA_W-1:0] tx_bus;
    logic              tx_en;
    logic              tx_err;
    logic              tx_hi;
    logic [NIB_W-1:0]  tx_up;
    logic              tx_upbad;
    logic              rx_hi;
    logic [NIB_W-1:0]  rx_lo;
    logic              rx_ctl_r;
    logic              pend_v;
    logic [DATA_W-1:0] pend_d;
    logic              pend_first;
    logic              in_frame;
    logic              err_seen;
    logic [DATA_W-1:0] out_d;
    logic              out_v;
    logic              out_sop;
    logic              out_eop;
    logic              out_err;
  } mpt_state_t;

  mpt_state_t        s_reg;
  mpt_state_t        s_next;
  logic [SYNC_W-1:0] sq;
  logic [TXW_W-1:0]  buf_q;
  logic              buf_v;
  logic              tx_pop;
  logic              tx_rise;
  logic              tx_fall;
  logic              rx_rise;
  logic              rx_fall;
  logic              got_byte;
  logic [DATA_W-1:0] got_d;
  logic              err_now;
  logic              rx_end;
  logic              err_final;
  mpt_mode_t         mode;

  // All link pins cross into clk_sys together, so data and clock keep their order
  mpt_sync #(.W(SYNC_W)) u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       ({link_mode, tx_clk, rx_clk, byte_rx_error, byte_rx_valid, byte_rx_bus}),
    .q       (sq)
  );

  // Absorbs client words while the link waits for its next clock edge
  mpt_buf2 #(.W(TXW_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (client_tx_valid),
    .in_ready  (client_tx_ready),
    .in_data   ({client_tx_frame_bad, client_tx_end_of_packet, client_tx_data}),
    .out_valid (buf_v),
    .out_ready (tx_pop),
    .out_data  (buf_q)
  );

  assign mode    = mpt_mode_t'(sq[SY_MODE +: MODE_W]);
  assign tx_rise = sq[SY_TCLK] && !s_reg.tclk_prev;
  assign tx_fall = !sq[SY_TCLK] && s_reg.tclk_prev;
  assign rx_rise = sq[SY_RCLK] && !s_reg.rclk_prev;
  assign rx_fall = !sq[SY_RCLK] && s_reg.rclk_prev;

  always_comb begin
    s_next           = s_reg;
    s_next.tclk_prev = sq[SY_TCLK];
    s_next.rclk_prev = sq[SY_RCLK];
    s_next.out_v     = 1'b0;
    tx_pop           = 1'b0;
    got_byte         = 1'b0;
    got_d            = '0;
    err_now          = 1'b0;
    rx_end           = 1'b0;
    err_final        = 1'b0;

    // Transmit: the client must keep pace with the link; an underrun ends the frame
    unique case (mode)
      MPT_DUAL: begin
        s_next.tx_err = 1'b0;
        if (tx_rise) begin
          s_next.tx_hi  = buf_v;
          s_next.tx_bus = TX_BUS_RST;
          s_next.tx_en  = buf_v;
          if (buf_v) begin
            tx_pop                  = 1'b1;
            s_next.tx_bus[NIB_W-1:0] = buf_q[NIB_W-1:0];
            s_next.tx_up            = buf_q[DATA_W-1:NIB_W];
            s_next.tx_upbad         = buf_q[TXW_BAD] && buf_q[TXW_EOP];
          end
        end else if (tx_fall && s_reg.tx_hi) begin
          s_next.tx_hi             = 1'b0;
          s_next.tx_bus[NIB_W-1:0] = s_reg.tx_up;
          // Control at the falling edge carries enable xor error
          s_next.tx_en             = !s_reg.tx_upbad;
        end
      end
      MPT_NIB: begin
        if (tx_rise) begin
          s_next.tx_bus = TX_BUS_RST;
          s_next.tx_err = 1'b0;
          s_next.tx_en  = 1'b0;
          if (s_reg.tx_hi) begin
            s_next.tx_hi             = 1'b0;
            s_next.tx_en             = 1'b1;
            s_next.tx_bus[NIB_W-1:0] = s_reg.tx_up;
            s_next.tx_err            = s_reg.tx_upbad;
          end else if (buf_v) begin
            tx_pop                   = 1'b1;
            s_next.tx_hi             = 1'b1;
            s_next.tx_en             = 1'b1;
            s_next.tx_bus[NIB_W-1:0] = buf_q[NIB_W-1:0];
            s_next.tx_up             = buf_q[DATA_W-1:NIB_W];
            s_next.tx_upbad          = buf_q[TXW_BAD] && buf_q[TXW_EOP];
          end
        end
      end
      default: begin
        // Byte mode; the unused code 2'b11 also lands here
        s_next.tx_hi = 1'b0;
        if (tx_rise) begin
          tx_pop        = buf_v;
          s_next.tx_en  = buf_v;
          s_next.tx_bus = buf_v ? buf_q[DATA_W-1:0] : TX_BUS_RST;
          s_next.tx_err = buf_v && buf_q[TXW_BAD] && buf_q[TXW_EOP];
        end
      end
    endcase

    // Receive: gather one byte per beat (two beats per byte in nibble mode), error sticks for the frame
    unique case (mode)
      MPT_DUAL: begin
        if (rx_rise) begin
          s_next.rx_ctl_r = sq[SY_RVALID];
          s_next.rx_lo    = sq[NIB_W-1:0];
          s_next.rx_hi    = sq[SY_RVALID];
          rx_end          = !sq[SY_RVALID];
        end else if (rx_fall && s_reg.rx_hi) begin
          s_next.rx_hi = 1'b0;
          got_byte     = 1'b1;
          got_d        = {sq[NIB_W-1:0], s_reg.rx_lo};
          err_now      = sq[SY_RVALID] ^ s_reg.rx_ctl_r;
        end
      end
      MPT_NIB: begin
        if (rx_rise) begin
          err_now = sq[SY_RVALID] && sq[SY_RERR];
          rx_end  = !sq[SY_RVALID];
          if (!sq[SY_RVALID]) begin
            s_next.rx_hi = 1'b0;
          end else if (!s_reg.rx_hi) begin
            s_next.rx_hi = 1'b1;
            s_next.rx_lo = sq[NIB_W-1:0];
          end else begin
            s_next.rx_hi = 1'b0;
            got_byte     = 1'b1;
            got_d        = {sq[NIB_W-1:0], s_reg.rx_lo};
          end
        end
      end
      default: begin
        s_next.rx_hi = 1'b0;
        if (rx_rise) begin
          got_byte = sq[SY_RVALID];
          got_d    = sq[DATA_W-1:0];
          err_now  = sq[SY_RVALID] && sq[SY_RERR];
          rx_end   = !sq[SY_RVALID];
        end
      end
    endcase

    // Any flagged beat counts, first nibble included; idle clears leftovers
    if (err_now) begin
      s_next.err_seen = 1'b1;
    end else if (rx_end) begin
      s_next.err_seen = 1'b0;
    end
    // One byte is held back so the last one can carry end of packet and error
    if (got_byte) begin
      if (s_reg.pend_v) begin
        s_next.out_v   = 1'b1;
        s_next.out_d   = s_reg.pend_d;
        s_next.out_sop = s_reg.pend_first;
        s_next.out_eop = 1'b0;
        s_next.out_err = 1'b0;
      end
      s_next.pend_v     = 1'b1;
      s_next.pend_d     = got_d;
      s_next.pend_first = !s_reg.in_frame;
      s_next.in_frame   = 1'b1;
    end else if (rx_end && s_reg.in_frame) begin
      err_final = s_reg.err_seen || err_now;
      if (s_reg.pend_v) begin
        s_next.out_v   = 1'b1;
        s_next.out_d   = s_reg.pend_d;
        s_next.out_sop = s_reg.pend_first;
        s_next.out_eop = 1'b1;
        s_next.out_err = err_final;
      end
      s_next.pend_v   = 1'b0;
      s_next.in_frame = 1'b0;
      s_next.err_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign byte_tx_bus               = s_reg.tx_bus;
  assign byte_tx_enable            = s_reg.tx_en;
  assign byte_tx_error             = s_reg.tx_err;
  assign client_rx_data            = s_reg.out_d;
  assign client_rx_valid           = s_reg.out_v;
  assign client_rx_start_of_packet = s_reg.out_sop;
  assign client_rx_end_of_packet   = s_reg.out_eop;
  assign client_rx_error           = {{(RX_ERR_W - 1){1'b0}}, s_reg.out_err};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  chk_byte_tx_launch: assert property (
    tx_rise && mode == MPT_BYTE && tx_pop
    |=> byte_tx_enable && byte_tx_bus == $past(buf_q[DATA_W-1:0]))
    else $error("byte transmit data or enable not launched");

  chk_byte_tx_bad: assert property (
    tx_rise && mode == MPT_BYTE && tx_pop && buf_q[TXW_BAD] && buf_q[TXW_EOP]
    |=> byte_tx_error && byte_tx_enable)
    else $error("bad frame without transmit error");

  chk_tx_en_edge: assert property (
    mode == MPT_NIB && $changed(byte_tx_enable) |-> $past(tx_rise))
    else $error("nibble enable moved off a rising edge");

  chk_dual_tx_low: assert property (
    tx_rise && mode == MPT_DUAL && tx_pop
    |=> byte_tx_enable && byte_tx_bus[NIB_W-1:0] == $past(buf_q[NIB_W-1:0]))
    else $error("dual-edge lower nibble not launched");

  chk_dual_tx_fall: assert property (
    tx_fall && mode == MPT_DUAL && s_reg.tx_hi
    |=> byte_tx_enable == !$past(s_reg.tx_upbad)
        && byte_tx_bus[NIB_W-1:0] == $past(s_reg.tx_up))
    else $error("dual-edge falling control or nibble wrong");

  chk_nib_tx_upper: assert property (
    tx_rise && mode == MPT_NIB && s_reg.tx_hi
    |=> byte_tx_enable && byte_tx_bus[NIB_W-1:0] == $past(s_reg.tx_up))
    else $error("nibble upper half not sent");

  chk_nib_err_once: assert property (
    tx_rise && mode == MPT_NIB && byte_tx_error |=> !byte_tx_error)
    else $error("nibble transmit error longer than one cycle");

  chk_byte_rx_pass: assert property (
    rx_rise && mode == MPT_BYTE && sq[SY_RVALID] && s_reg.pend_v
    |=> client_rx_valid && !client_rx_end_of_packet
        && client_rx_data == $past(s_reg.pend_d))
    else $error("byte receive beat not passed on");

  chk_dual_rx_join: assert property (
    rx_fall && mode == MPT_DUAL && s_reg.rx_hi
    |=> s_reg.pend_v && s_reg.pend_d == {$past(sq[NIB_W-1:0]), $past(s_reg.rx_lo)})
    else $error("dual-edge receive byte misassembled");

  chk_nib_rx_join: assert property (
    rx_rise && mode == MPT_NIB && sq[SY_RVALID] && s_reg.rx_hi
    |=> s_reg.pend_d == {$past(sq[NIB_W-1:0]), $past(s_reg.rx_lo)})
    else $error("nibble receive byte misassembled");

  chk_rx_err_end: assert property (
    rx_end && s_reg.in_frame && s_reg.pend_v && (s_reg.err_seen || err_now)
    |=> client_rx_valid && client_rx_end_of_packet && client_rx_error[RX_ERR_PHY])
    else $error("receive error not flagged at end of packet");

  cov_rx_err_frame: cover property (
    client_rx_valid && client_rx_end_of_packet && client_rx_error[RX_ERR_PHY]);
  cov_tx_stall: cover property (client_tx_valid && !client_tx_ready);
  cov_dual_bad: cover property (tx_fall && mode == MPT_DUAL && s_reg.tx_hi && s_reg.tx_upbad);
  cov_nib_err: cover property (mode == MPT_NIB && byte_tx_error);

endmodule
`default_nettype wire

// >>> mpt_pkg.sv
// Shared constants and types of the MAC to PHY frame timing block
`default_nettype none
package mpt_pkg;

  // Media interface style, taken from the link_mode pins
  typedef enum logic [1:0] {
    MPT_BYTE = 2'b00,
    MPT_DUAL = 2'b01,
    MPT_NIB  = 2'b10
  } mpt_mode_t;

  localparam int unsigned SYS_CLK_HZ  = 25_000_000;
  localparam int          DATA_W      = 8;
  localparam int          NIB_W       = 4;
  localparam int          MODE_W      = 2;
  localparam int          RX_ERR_W    = 6;
  localparam int          RX_ERR_PHY  = 0;
  localparam int          BUF_DEPTH   = 2;

  // Buffer word layout: {frame_bad, end_of_packet, data}
  localparam int          TXW_W       = DATA_W + 2;
  localparam int          TXW_EOP     = DATA_W;
  localparam int          TXW_BAD     = DATA_W + 1;

  // Synchroniser word layout: {mode, tx_clk, rx_clk, rx_error, rx_valid, rx_bus}
  localparam int          SYNC_W      = MODE_W + 4 + DATA_W;
  localparam int          SY_RVALID   = DATA_W;
  localparam int          SY_RERR     = DATA_W + 1;
  localparam int          SY_RCLK     = DATA_W + 2;
  localparam int          SY_TCLK     = DATA_W + 3;
  localparam int          SY_MODE     = DATA_W + 4;

  localparam logic [DATA_W-1:0] TX_BUS_RST = 8'h00;

endpackage
`default_nettype wire

// >>> mpt_sync.sv
// Two-flop synchroniser for pins arriving from outside the system clock
`timescale 1ns/100ps
`default_nettype none
module mpt_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         srst,
  // Pins and their synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import mpt_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mpt_sync_t;

  mpt_sync_t s_reg;
  mpt_sync_t s_next;

  // First stage feeds only the second stage
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;

endmodule
`default_nettype wire

// >>> mpt_buf2.sv
// Small valid/ready buffer with registered handshake outputs
`timescale 1ns/100ps
`default_nettype none
module mpt_buf2 #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         srst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  import mpt_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr;
    logic [PW-1:0]           rd;
    logic [CW-1:0]           cnt;
    logic                    rdy;
    logic                    vld;
  } mpt_buf_t;

  mpt_buf_t s_reg;
  mpt_buf_t s_next;
  logic     push;
  logic     pop;

  // Flags registered so the client sees ready straight from a flop
  always_comb begin
    s_next = s_reg;
    push   = in_valid && s_reg.rdy;
    pop    = s_reg.vld && out_ready;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = (s_reg.wr == PW'(DEPTH - 1)) ? '0 : s_reg.wr + 1'b1;
    end
    if (pop) begin
      s_next.rd = (s_reg.rd == PW'(DEPTH - 1)) ? '0 : s_reg.rd + 1'b1;
    end
    s_next.cnt = s_reg.cnt + CW'(push) - CW'(pop);
    s_next.rdy = (s_next.cnt != CW'(DEPTH));
    s_next.vld = (s_next.cnt != '0);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready  = s_reg.rdy;
  assign out_valid = s_reg.vld;
  assign out_data  = s_reg.mem[s_reg.rd];

endmodule
`default_nettype wire

// >>> mpt_phy_model.sv
// PHY side partner: link clocks, receive frames, transmit capture
`timescale 1ns/100ps
`default_nettype none
module mpt_phy_model (
  // Link style
  input  wire logic [1:0] link_mode,
  // Transmit link
  output logic            tx_clk,
  input  wire logic [7:0] byte_tx_bus,
  input  wire logic       byte_tx_enable,
  input  wire logic       byte_tx_error,
  // Receive link
  output logic            rx_clk,
  output logic      [7:0] byte_rx_bus,
  output logic            byte_rx_valid,
  output logic            byte_rx_error
);
  import mpt_pkg::*;
  logic [7:0] tx_q[$];
  logic       tx_run    = 1'b1;
  logic       tx_act    = 1'b0;
  logic       tx_hi     = 1'b0;
  logic       lo_en     = 1'b0;
  logic [7:0] lo_byte   = 8'h00;
  integer     tx_err_n  = 0;
  int         tx_frames = 0;

  initial begin
    rx_clk = 1'b0;
    byte_rx_bus = 8'h00;
    byte_rx_valid = 1'b0;
    byte_rx_error = 1'b0;
    tx_clk = 1'b0;
    // Odd offset keeps the link edges off the system clock grid
    #17.3;
    forever begin
      #160;
      if (tx_run) tx_clk = ~tx_clk;
    end
  end

  task automatic frame_edge(input logic v);
    if (v) tx_act = 1'b1;
    else if (tx_act) begin
      tx_act = 1'b0;
      tx_hi = 1'b0;
      tx_frames++;
    end
  endtask

  always @(negedge tx_clk) begin
    if (link_mode == MPT_DUAL) begin
      lo_byte = byte_tx_bus;
      lo_en = byte_tx_enable;
    end
  end

  always @(posedge tx_clk) begin
    if (link_mode == MPT_DUAL) begin
      if (lo_en) begin
        tx_q.push_back({byte_tx_bus[3:0], lo_byte[3:0]});
        tx_err_n += integer'(!byte_tx_enable);
      end
      // Dual-edge errors travel on control only, never on the error pin
      tx_err_n += integer'(byte_tx_error);
      frame_edge(lo_en);
    end else if (link_mode == MPT_NIB) begin
      if (byte_tx_enable) begin
        if (tx_hi) tx_q.push_back({byte_tx_bus[3:0], lo_byte[3:0]});
        else lo_byte = byte_tx_bus;
        tx_hi = !tx_hi;
      end
      tx_err_n += integer'(byte_tx_error);
      frame_edge(byte_tx_enable);
    end else begin
      if (byte_tx_enable) tx_q.push_back(byte_tx_bus);
      tx_err_n += integer'(byte_tx_error);
      frame_edge(byte_tx_enable);
    end
  end

  // Data settles half a half-period before each receive clock edge
  task automatic half(input logic c, input logic [7:0] d, input logic v, input logic e);
    byte_rx_bus = d;
    byte_rx_valid = v;
    byte_rx_error = e;
    #80;
    rx_clk = c;
    #80;
  endtask

  // Receive clock runs only in frames plus two idle beats that close them
  task automatic rx_frame(input logic [7:0] q[$], input int bad_at);
    logic [7:0] b;
    logic       e;
    #13.7;
    foreach (q[i]) begin
      b = q[i];
      e = (i == bad_at);
      case (link_mode)
        MPT_DUAL: begin
          half(1'b1, {4'h0, b[3:0]}, 1'b1, 1'b0);
          half(1'b0, {4'h0, b[7:4]}, !e, 1'b0);
        end
        MPT_NIB: begin
          half(1'b1, {4'h0, b[3:0]}, 1'b1, e);
          half(1'b0, {4'h0, b[3:0]}, 1'b1, e);
          // Error lasts one clock, on the low nibble only: the shortest allowed
          half(1'b1, {4'h0, b[7:4]}, 1'b1, 1'b0);
          half(1'b0, {4'h0, b[7:4]}, 1'b1, 1'b0);
        end
        default: begin
          half(1'b1, b, 1'b1, e);
          half(1'b0, b, 1'b1, e);
        end
      endcase
    end
    // Released bus shows the inverse so stale data cannot pass
    repeat (2) begin
      half(1'b1, ~b, 1'b0, 1'b0);
      half(1'b0, ~b, 1'b0, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the MAC to PHY frame timing block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
  import mpt_pkg::*;
  logic                clk_sys = 1'b0;
  logic                srst = 1'b1;
  logic [MODE_W-1:0]   link_mode = 2'b00;
  logic [DATA_W-1:0]   client_tx_data = 8'h00;
  logic                client_tx_valid = 1'b0;
  logic                client_tx_end_of_packet = 1'b0;
  logic                client_tx_frame_bad = 1'b0;
  logic                client_tx_ready;
  logic [DATA_W-1:0]   client_rx_data;
  logic                client_rx_valid;
  logic                client_rx_start_of_packet;
  logic                client_rx_end_of_packet;
  logic [RX_ERR_W-1:0] client_rx_error;
  logic                tx_clk;
  logic                rx_clk;
  logic [DATA_W-1:0]   byte_tx_bus;
  logic                byte_tx_enable;
  logic                byte_tx_error;
  logic [DATA_W-1:0]   byte_rx_bus;
  logic                byte_rx_valid;
  logic                byte_rx_error;
  logic [DATA_W-1:0]   rx_got[$];
  logic [RX_ERR_W-1:0] rx_err_last;
  int                  rx_frames = 0;
  int                  failures = 0;
  int                  num_checks = 0;

  always #20 clk_sys = ~clk_sys;

  mpt_frame_timing mpt_frame_timing_inst (
    .clk_sys(clk_sys), .srst(srst), .link_mode(link_mode),
    .client_tx_data(client_tx_data), .client_tx_valid(client_tx_valid),
    .client_tx_ready(client_tx_ready), .client_tx_end_of_packet(client_tx_end_of_packet),
    .client_tx_frame_bad(client_tx_frame_bad), .client_rx_data(client_rx_data),
    .client_rx_valid(client_rx_valid), .client_rx_start_of_packet(client_rx_start_of_packet),
    .client_rx_end_of_packet(client_rx_end_of_packet), .client_rx_error(client_rx_error),
    .tx_clk(tx_clk), .byte_tx_bus(byte_tx_bus), .byte_tx_enable(byte_tx_enable),
    .byte_tx_error(byte_tx_error), .rx_clk(rx_clk), .byte_rx_bus(byte_rx_bus),
    .byte_rx_valid(byte_rx_valid), .byte_rx_error(byte_rx_error));

  mpt_phy_model mpt_phy_model_inst (
    .link_mode(link_mode), .tx_clk(tx_clk), .byte_tx_bus(byte_tx_bus),
    .byte_tx_enable(byte_tx_enable), .byte_tx_error(byte_tx_error), .rx_clk(rx_clk),
    .byte_rx_bus(byte_rx_bus), .byte_rx_valid(byte_rx_valid), .byte_rx_error(byte_rx_error));

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic timeout();
    failures++;
    print_verdict();
  endtask

  // Receive pulses last one cycle, so every cycle is looked at
  always @(negedge clk_sys) begin
    if (client_rx_valid === 1'b1) begin
      `CHK(client_rx_start_of_packet, rx_got.size() == 0)
      rx_got.push_back(client_rx_data);
      if (client_rx_end_of_packet === 1'b1) begin
        rx_err_last = client_rx_error;
        rx_frames++;
      end
    end
  end

  // Word is held until ready is seen high at a rising edge
  task automatic push(input logic [7:0] d, input logic eop, input logic bad);
    int n;
    @(negedge clk_sys);
    client_tx_valid = 1'b1;
    client_tx_data = d;
    client_tx_end_of_packet = eop;
    client_tx_frame_bad = eop ? bad : 1'($urandom);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (client_tx_ready !== 1'b1 && n < 200);
    if (n >= 200) timeout();
  endtask

  task automatic tx_frame(input logic [7:0] q[$], input logic bad, input logic stall);
    int f;
    int k;
    f = mpt_phy_model_inst.tx_frames;
    mpt_phy_model_inst.tx_q.delete();
    mpt_phy_model_inst.tx_err_n = 0;
    if (stall) mpt_phy_model_inst.tx_run = 1'b0;
    foreach (q[i]) begin
      if (stall && i == 2) begin
        @(negedge clk_sys);
        client_tx_valid = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK(client_tx_ready, 1'b0)
        mpt_phy_model_inst.tx_run = 1'b1;
      end
      push(q[i], i == q.size() - 1, bad);
    end
    @(negedge clk_sys);
    client_tx_valid = 1'b0;
    k = 0;
    while (mpt_phy_model_inst.tx_frames == f && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 2000) timeout();
    @(negedge clk_sys);
    `CHK(byte_tx_enable, 1'b0)
    `CHK(mpt_phy_model_inst.tx_q.size(), q.size())
    foreach (q[i]) `CHK(mpt_phy_model_inst.tx_q[i], q[i])
    `CHK(mpt_phy_model_inst.tx_err_n, bad ? 1 : 0)
  endtask

  // Expected error word: bit 0 only when the PHY flagged a beat
  function automatic logic [RX_ERR_W-1:0] exp_rx_err(input int pos);
    return RX_ERR_W'(pos >= 0);
  endfunction

  task automatic rx_chk(input logic [7:0] q[$], input int pos);
    int f;
    int k;
    rx_got.delete();
    f = rx_frames;
    mpt_phy_model_inst.rx_frame(q, pos);
    k = 0;
    while (rx_frames == f && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 200) timeout();
    `CHK(rx_got.size(), q.size())
    foreach (q[i]) `CHK(rx_got[i], q[i])
    `CHK(rx_err_last, exp_rx_err(pos))
  endtask

  initial begin
    logic [7:0] tq[$];
    logic [7:0] rq[$];
    int         n;
    int         pos;
    void'($urandom(32'hF5F8));
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    repeat (4) @(negedge clk_sys);
    // Mode 11 must behave as byte-wide
    for (int m = 0; m < 4; m++) begin
      link_mode = 2'(m);
      repeat (8) @(negedge clk_sys);
      for (int k = 0; k < 3; k++) begin
        n = (k == 2) ? 1 : 3 + $urandom_range(4);
        tq.delete();
        rq.delete();
        for (int i = 0; i < n; i++) begin
          tq.push_back(8'($urandom));
          rq.push_back(8'($urandom));
        end
        pos = (k == 1) ? int'($urandom_range(n - 1)) : -1;
        // Both directions at once; stall only in the first byte-mode frame, before its third word
        fork
          tx_frame(tq, k != 0, m == 0 && k == 0);
          rx_chk(rq, pos);
        join
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
